// *** rtl/bypass_pkg.sv ***
// constants, types and register map for the channel bypass and vote block
package bypass_pkg;
	localparam int unsigned NUM_CH = 4;
	localparam int unsigned VOTE_MIN = 2;
	// register byte offsets
	localparam logic [7:0] ctrl_off     = 8'h00;
	localparam logic [7:0] status_off   = 8'h04;
	localparam logic [7:0] int_stat_off = 8'h08;
	localparam logic [7:0] int_en_off   = 8'h0c;
	localparam logic [7:0] int_clr_off  = 8'h10;
	localparam logic [7:0] param_off    = 8'h14;
	// ctrl fields
	localparam int unsigned CTRL_TEST_BIT = 0;
	localparam int unsigned CTRL_MANIND_BIT = 1;
	// interrupt status fields
	localparam int unsigned IRQ_ALARM = 0;
	localparam int unsigned IRQ_TRIP = 1;
	localparam int unsigned IRQ_REFUSED = 2;
	localparam int unsigned IRQ_DONE = 3;
	localparam int unsigned IRQ_W = 4;
	localparam logic [31:0] ctrl_rst = 32'h0000_0000;
	localparam logic [31:0] param_rst = 32'h0000_0000;
	// per-channel source selection
	typedef enum logic [1:0] {
		sel_forward = 2'b00,
		sel_notrip  = 2'b01,
		sel_trip    = 2'b11
	} sel_t;
endpackage

// *** rtl/sync2.sv ***
// two-flop level synchroniser
`timescale 1ns/1ns
module sync2 #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         reset,
	// level in and out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// *** rtl/chan_select.sv ***
// one channel: choose forwarded, forced no-trip or forced trip value
`timescale 1ns/1ns
module chan_select (
	// clock and reset
	input  wire logic mclk,
	input  wire logic reset,
	// packet from the safety function module
	input  wire logic pkt_strobe,
	input  wire logic pkt_valid,
	input  wire logic pkt_result,
	input  wire logic pkt_oos,
	// synchronised trip/bypass switch, high selects trip
	input  wire logic sw_trip,
	// outputs
	output logic      vote_out,
	output logic      oos_r,
	output logic      alarm_r,
	output logic      forced_r
);
	logic result_r;
	logic use_switch;
	bypass_pkg::sel_t sel;

	// out-of-service comes only from the packet field
	assign use_switch = alarm_r | oos_r;
	assign sel = !use_switch ? bypass_pkg::sel_forward
	           : (sw_trip ? bypass_pkg::sel_trip : bypass_pkg::sel_notrip);

	// latch packet content; an invalid packet keeps alarm until a good one
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			result_r <= 1'b0;
			oos_r    <= 1'b0;
			alarm_r  <= 1'b1; // no packet yet counts as no valid response
		end else if (pkt_strobe) begin
			alarm_r <= !pkt_valid;
			if (pkt_valid) begin
				result_r <= pkt_result;
				oos_r    <= pkt_oos;
			end
		end
	end

	// the value to the voting stage
	always_comb begin
		case (sel)
			bypass_pkg::sel_forward: vote_out = result_r;
			bypass_pkg::sel_notrip:  vote_out = 1'b0;
			bypass_pkg::sel_trip:    vote_out = 1'b1;
			default:                 vote_out = 1'b1;     // fail safe to trip
		endcase
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			forced_r <= 1'b0;
		end else begin
			forced_r <= use_switch;
		end
	end
endmodule

// *** rtl/channel_bypass_vote_logic.sv ***
// top: four channel bypass selection, 2oo4 vote, status and apb registers
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module channel_bypass_vote_logic #(
	parameter int unsigned N = bypass_pkg::NUM_CH
) (
	// clock and reset
	input  wire logic          mclk,
	input  wire logic          reset,
	// apb slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// packets from the safety function modules, one per channel
	input  wire logic [N-1:0]  pkt_strobe,
	input  wire logic [N-1:0]  pkt_valid,
	input  wire logic [N-1:0]  pkt_result,
	input  wire logic [N-1:0]  pkt_oos,
	// trip/bypass switch levels from the hardwired input module backplane
	input  wire logic [N-1:0]  sw_trip_bp,
	// cooling valve open position
	input  wire logic          valve_open,
	// voting result, trip breaker drive and cooling completion
	output logic               trip_vote,
	output logic               breaker_trip,
	output logic               cooling_done,
	// status to control and display systems
	output logic [N-1:0]       stat_bypass,
	output logic [N-1:0]       stat_trip,
	output logic [N-1:0]       stat_oos,
	output logic [N-1:0]       stat_alarm,
	output logic               manual_bypass_ind,
	// interrupt
	output logic               irq
);
	logic [N-1:0] sw_trip_s;
	logic [N-1:0] vote_in;
	logic [N-1:0] oos;
	logic [N-1:0] alarm;
	logic [N-1:0] forced;
	logic [31:0]  ctrl_r;
	logic [31:0]  param_r;
	logic [bypass_pkg::IRQ_W-1:0] ist_r;
	logic [bypass_pkg::IRQ_W-1:0] ien_r;
	logic [bypass_pkg::IRQ_W-1:0] ev;
	logic [bypass_pkg::IRQ_W-1:0] clr;
	logic [31:0]  rd_mux;
	logic         wr_acc;
	logic         rd_acc;
	logic         hit;
	logic         vote;
	logic         vote_d_r;
	logic         any_oos;
	logic         param_wr;
	logic [2:0]   cnt;

	// switch levels arrive as backplane logic and are synchronised first
	sync2 #(.W(N)) u_sw_sync (
		.mclk  (mclk),
		.reset (reset),
		.d     (sw_trip_bp),
		.q     (sw_trip_s)
	);

	// one selector per channel; the divisions after the vote add no bypass
	generate
		for (genvar i = 0; i < N; i++) begin : g_ch
			chan_select u_sel (
				.mclk       (mclk),
				.reset      (reset),
				.pkt_strobe (pkt_strobe[i]),
				.pkt_valid  (pkt_valid[i]),
				.pkt_result (pkt_result[i]),
				.pkt_oos    (pkt_oos[i]),
				.sw_trip    (sw_trip_s[i]),
				.vote_out   (vote_in[i]),
				.oos_r      (oos[i]),
				.alarm_r    (alarm[i]),
				.forced_r   (forced[i])
			);
		end
	endgenerate

	// count trip votes; threshold is fixed whatever the bypass state
	always_comb begin
		cnt = 3'd0;
		for (int k = 0; k < N; k++) begin
			cnt = cnt + {2'b00, vote_in[k]};
		end
	end
	assign vote = (cnt >= 3'(bypass_pkg::VOTE_MIN));

	// apb decode; zero wait states
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & !pwrite;
	assign hit = (paddr == bypass_pkg::ctrl_off) | (paddr == bypass_pkg::status_off)
	           | (paddr == bypass_pkg::int_stat_off) | (paddr == bypass_pkg::int_en_off)
	           | (paddr == bypass_pkg::int_clr_off) | (paddr == bypass_pkg::param_off);
	assign any_oos = |oos;
	assign param_wr = wr_acc & (paddr == bypass_pkg::param_off);
	assign clr = (wr_acc && paddr == bypass_pkg::int_clr_off)
	           ? pwdata[bypass_pkg::IRQ_W-1:0] : '0;

	// events that set sticky status bits
	assign ev[bypass_pkg::IRQ_ALARM]   = |alarm;
	assign ev[bypass_pkg::IRQ_TRIP]    = vote & !vote_d_r;
	assign ev[bypass_pkg::IRQ_REFUSED] = param_wr & !any_oos;
	assign ev[bypass_pkg::IRQ_DONE]    = cooling_done;

	// read mux; write-only clear reads zero
	always_comb begin
		case (paddr)
			bypass_pkg::ctrl_off:     rd_mux = ctrl_r;
			bypass_pkg::status_off:   rd_mux = {16'h0000, alarm, oos, forced, vote_in};
			bypass_pkg::int_stat_off: rd_mux = {28'h0000000, ist_r};
			bypass_pkg::int_en_off:   rd_mux = {28'h0000000, ien_r};
			bypass_pkg::param_off:    rd_mux = param_r;
			default:                  rd_mux = 32'h0000_0000;
		endcase
	end

	// apb outputs registered
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & !penable;
			pslverr <= psel & !penable & !hit;
			prdata  <= (psel & !penable & !pwrite) ? rd_mux : prdata;
		end
	end

	// control and parameter registers
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ctrl_r  <= bypass_pkg::ctrl_rst;
			param_r <= bypass_pkg::param_rst;
			ien_r   <= '0;
		end else begin
			if (wr_acc && pready && paddr == bypass_pkg::ctrl_off) ctrl_r <= pwdata;
			if (wr_acc && pready && paddr == bypass_pkg::int_en_off)
				ien_r <= pwdata[bypass_pkg::IRQ_W-1:0];
			if (param_wr && pready && any_oos) param_r <= pwdata;
		end
	end

	// sticky status: set wins over clear
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ist_r <= '0;
		end else begin
			ist_r <= (ist_r & ~(pready ? clr : '0)) | (ev & {bypass_pkg::IRQ_W{1'b1}}
			         & {1'b1, 1'b1, pready, 1'b1});
		end
	end

	// vote, breaker, completion and status outputs
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			vote_d_r          <= 1'b0;
			trip_vote         <= 1'b0;
			breaker_trip      <= 1'b0;
			cooling_done      <= 1'b0;
			stat_bypass       <= '0;
			stat_trip         <= '0;
			stat_oos          <= '0;
			stat_alarm        <= '0;
			manual_bypass_ind <= 1'b0;
			irq               <= 1'b0;
		end else begin
			vote_d_r     <= vote;
			trip_vote    <= vote;
			// breaker drive held off while the trip logic is tested
			breaker_trip <= vote & !ctrl_r[bypass_pkg::CTRL_TEST_BIT];
			// completion needs the valve open report, not the command alone
			cooling_done <= vote & valve_open;
			stat_bypass  <= forced & ~sw_trip_s;
			stat_trip    <= vote_in;
			stat_oos     <= oos;
			stat_alarm   <= alarm;
			manual_bypass_ind <= ctrl_r[bypass_pkg::CTRL_MANIND_BIT] | (|(forced & ~sw_trip_s));
			irq          <= |(ist_r & ien_r);
		end
	end
endmodule

// *** verification/bypass_checker.sv ***
// port assertions for the channel bypass and vote block
`timescale 1ns/1ns
module bypass_checker #(
	parameter int unsigned N = bypass_pkg::NUM_CH
) (
	// clock and reset
	input wire logic         mclk,
	input wire logic         reset,
	// apb
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pwrite,
	input wire logic [7:0]   paddr,
	input wire logic [31:0]  pwdata,
	input wire logic         pready,
	input wire logic         pslverr,
	// packets and alarms
	input wire logic [N-1:0] pkt_strobe,
	input wire logic [N-1:0] pkt_valid,
	input wire logic [N-1:0] stat_alarm,
	// vote side
	input wire logic         valve_open,
	input wire logic         trip_vote,
	input wire logic         breaker_trip,
	input wire logic         cooling_done,
	input wire logic         manual_bypass_ind
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// accepted ctrl write, and a packet that failed its check
	sequence ctrl_wr;
		psel && penable && pready && pwrite && paddr == 8'h00;
	endsequence
	// channel 2 is the one the bench sends an invalid packet on
	sequence bad_pkt;
		pkt_strobe[2] && !pkt_valid[2];
	endsequence
	chk_apb_wait: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("ready held");
	chk_err_map: assert property (pready && paddr > 8'h14 |-> pslverr)
		else $error("unmapped access accepted");
	chk_cool_valve: assert property (cooling_done |-> $past(valve_open))
		else $error("done without valve open");
	chk_breaker_vote: assert property (breaker_trip |-> trip_vote)
		else $error("breaker without vote");
	chk_test_hold: assert property (ctrl_wr ##0 pwdata[0] |-> ##2 !breaker_trip)
		else $error("breaker driven in test");
	// a bypassed channel may also light the indication, so only the set case is checked
	chk_man_ind: assert property (ctrl_wr ##0 pwdata[1] |-> ##2 manual_bypass_ind)
		else $error("manual indication wrong");
	chk_alarm_pkt: assert property (bad_pkt |-> ##[1:3] stat_alarm[2])
		else $error("no alarm on bad packet");
endmodule
bind channel_bypass_vote_logic bypass_checker #(.N(N)) u_chk (.mclk, .reset, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .pkt_strobe, .pkt_valid, .stat_alarm,
	.valve_open, .trip_vote, .breaker_trip, .cooling_done, .manual_bypass_ind);

// *** verification/sfm_model.sv ***
// safety function modules: one packet per channel on request
`timescale 1ns/1ns
module sfm_model (
	// clock and request
	input wire logic [3:0] go,
	input wire logic       mclk,
	input wire logic [3:0] valid,
	input wire logic [3:0] result,
	input wire logic [3:0] oos,
	// packet lines
	output logic     [3:0] pkt_strobe,
	output logic     [3:0] pkt_valid,
	output logic     [3:0] pkt_result,
	output logic     [3:0] pkt_oos
);
	initial {pkt_strobe, pkt_valid, pkt_result, pkt_oos} = '0;
	// fields toggle between packets so stale data is never taken as news
	always @(posedge mclk) begin
		pkt_strobe <= go;
		pkt_valid <= go & valid | ~go & ~pkt_valid;
		pkt_result <= go & result | ~go & ~pkt_result;
		pkt_oos <= go & oos | ~go & ~pkt_oos;
	end
endmodule

// *** verification/tb.sv ***
// self-checking bench for the channel bypass and vote block
`timescale 1ns/1ns
module tb;
	logic        mclk, reset, psel, penable, pwrite, valve_open;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, d;
	logic        pready, pslverr, trip_vote, breaker_trip, cooling_done, man_ind, irq;
	logic [3:0]  go, valid, result, oos, sw_trip_bp, stat_oos, stat_alarm;
	logic [3:0]  stat_bypass, stat_trip;
	logic [3:0]  pkt_strobe, pkt_valid, pkt_result, pkt_oos;
	logic [32:0] exp_q[$], msk_q[$];
	int          failures, checked, seed;
	sfm_model u_sfm (.mclk, .go, .valid, .result, .oos, .pkt_strobe, .pkt_valid,
		.pkt_result, .pkt_oos);
	channel_bypass_vote_logic u_dut (.mclk, .reset, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .pkt_strobe, .pkt_valid, .pkt_result,
		.pkt_oos, .sw_trip_bp, .valve_open, .trip_vote, .breaker_trip, .cooling_done,
		.stat_bypass, .stat_trip, .stat_oos, .stat_alarm,
		.manual_bypass_ind(man_ind), .irq);
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic fail(input string s);
		failures++;
		$display("CHECK FAILED %0t %s", $time, s);
	endtask
	task automatic cmp_port(input logic g, input logic e, input string s);
		checked++;
		if (g !== e) fail(s);
	endtask
	// per-channel status vectors
	task automatic cmp_vec(input logic [3:0] g, input logic [3:0] e, input string s);
		checked++;
		if (g !== e) fail(s);
	endtask
	task automatic cmp_rd(input logic [32:0] g);
		logic [32:0] e, m;
		e = exp_q.pop_front();
		m = msk_q.pop_front();
		checked++;
		if ((g & m) !== (e & m)) fail("read data");
	endtask
	task automatic end_sim;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// request held until the edge where ready is seen
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge mclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge mclk);
		end
		if (pready !== 1'b1) begin
			fail("apb timeout");
			end_sim();
		end
		{psel, penable} <= 2'b00;
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e, m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic tick;
		repeat (4) @(posedge mclk);
	endtask
	// switch gets time to pass its synchroniser before each packet
	task automatic pkt(input logic [3:0] v, r, o);
		tick();
		{go, valid, result, oos} <= {4'hf, v, r, o};
		@(posedge mclk);
		go <= 4'h0;
		tick();
	endtask
	// read data is compared at the edge that completes the read
	always @(posedge mclk) if (psel && penable && pready === 1'b1 && !pwrite) cmp_rd({pslverr, prdata});
	initial begin
		{psel, penable, pwrite, paddr, pwdata, go, valid, result, oos, sw_trip_bp} = '0;
		{valve_open, failures, checked, seed} = {1'b0, 32'h0, 32'h0, 32'h0000_814f};
		reset = 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		repeat (8) begin
			d = $random(seed);
			pkt(4'hf, d[3:0], 4'h0);
			rd(8'h04, {29'h0, d[3:0]}, 33'h0_0000_ffff);
			cmp_port(trip_vote, $countones(d[3:0]) >= 2, "vote");
		end
		// ch0 bypassed while its own result trips, ch2 sends an invalid packet with switch in trip
		sw_trip_bp <= 4'h4;
		pkt(4'hb, 4'h3, 4'h1);
		rd(8'h04, {17'h0, 16'h4156}, 33'h0_0000_ffff);
		cmp_port(trip_vote, 1'b1, "alarm vote");
		cmp_vec(stat_bypass, 4'h1, "bypass status");
		cmp_vec(stat_trip, 4'h6, "trip status");
		cmp_vec(stat_oos, 4'h1, "oos status");
		cmp_vec(stat_alarm, 4'h4, "alarm status");
		d = $random(seed);
		xfer(1'b1, 8'h14, d);
		rd(8'h14, {1'b0, d}, '1);
		sw_trip_bp <= 4'h1;
		pkt(4'hf, 4'h0, 4'h1);
		rd(8'h04, {17'h0, 16'h0111}, '1);
		cmp_port(trip_vote, 1'b0, "one vote");
		cmp_vec(stat_bypass, 4'h0, "forced trip no bypass");
		cmp_vec(stat_trip, 4'h1, "forced trip status");
		pkt(4'hf, 4'h8, 4'h1);
		cmp_port(trip_vote, 1'b1, "partial trip");
		cmp_port(cooling_done, 1'b0, "cooling early");
		valve_open <= 1'b1;
		pkt(4'hf, 4'h3, 4'h0);
		cmp_port(breaker_trip, 1'b1, "breaker");
		cmp_port(cooling_done, 1'b1, "cooling");
		xfer(1'b1, 8'h00, 32'h3);
		tick();
		cmp_port(breaker_trip, 1'b0, "test hold");
		cmp_port(man_ind, 1'b1, "manual ind");
		// refused write raises a masked event, then enable and clear it
		xfer(1'b1, 8'h10, 32'hf);
		xfer(1'b1, 8'h14, 32'h55);
		rd(8'h14, {1'b0, d}, '1);
		cmp_port(irq, 1'b0, "masked");
		xfer(1'b1, 8'h0c, 32'h4);
		tick();
		cmp_port(irq, 1'b1, "irq");
		rd(8'h08, 33'h4, 33'h4);
		xfer(1'b1, 8'h10, 32'h4);
		tick();
		cmp_port(irq, 1'b0, "cleared");
		rd(8'h10, 33'h0, '1);
		rd(8'h40, 33'h1_0000_0000, 33'h1_0000_0000);
		tick();
		end_sim();
	end
endmodule
